/* rtl/starter_pkg.sv */
package starter_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 5;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [15:0] RELAY_SETTLE_TICKS = 16'h0032;
	localparam logic [1:0] ZS_REPEAT = 2'h3;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_START_LIM = 8'h04;
	localparam logic [7:0] ADDR_RAMPEND_MON = 8'h08;
	localparam logic [7:0] ADDR_BRAKE_MAX = 8'h0C;
	localparam logic [7:0] ADDR_MC_MON = 8'h10;
	localparam logic [7:0] ADDR_CONT_DLY = 8'h14;
	localparam logic [7:0] ADDR_PHASE = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam int CTRL_ACK_EN = 0;
	localparam int CTRL_ZS_EN = 1;
	localparam int CTRL_ROT_EN = 2;
	localparam int CTRL_BRAKE_MODE = 3;
	localparam int PHASE_REP_LSB = 16;
	localparam logic [3:0] CTRL_RST = 4'h8;
	localparam logic [15:0] START_LIM_RST = 16'h2710;
	localparam logic [15:0] RAMPEND_MON_RST = 16'h03E8;
	localparam logic [15:0] BRAKE_MAX_RST = 16'h2710;
	localparam logic [15:0] MC_MON_RST = 16'h01F4;
	localparam logic [15:0] CONT_DLY_RST = 16'h0064;
	localparam logic [15:0] PHASE_LIM_RST = 16'h0014;
	localparam logic [3:0] PHASE_REP_RST = 4'h3;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000, ST_SOFT_START = 3'b001, ST_RAMP_END = 3'b010,
		ST_SOFT_STOP = 3'b011, ST_BRAKING = 3'b100, ST_SWITCH_OFF = 3'b101
	} op_state_e;

	typedef enum logic [3:0] {
		FC_NONE = 4'h0, FC_W_BRAKE_CUR = 4'h1, FC_W_DEV_TEMP = 4'h2, FC_DEV_TEMP = 4'h3,
		FC_MAIN_CONT = 4'h4, FC_CPU = 4'h5, FC_MOTOR_TEMP = 4'h6, FC_OVERLOAD = 4'h7,
		FC_PHASE = 4'h8, FC_POWER_UNIT = 4'h9, FC_RAMP_END = 4'hA, FC_RELAY = 4'hB,
		FC_ROTARY = 4'hC, FC_START_CUR = 4'hD, FC_ZS_LVL1 = 4'hE, FC_ZS_LVL2 = 4'hF
	} fault_code_e;

	typedef enum logic [2:0] {
		SEV_NONE = 3'b000, SEV_WARN = 3'b001, SEV_T1 = 3'b010, SEV_T2 = 3'b011, SEV_T4 = 3'b100
	} severity_e;

	typedef struct packed {
		logic heatsink_margin_low;
		logic heatsink_over;
		logic line_voltage_present;
		logic cpu_error;
		logic motor_temp_trip;
		logic overcurrent;
		logic phase_bad;
		logic power_unit_fault;
		logic ramp_done;
		logic current_below_limit;
		logic ramp_down_done;
		logic contactor_sensed;
		logic rotation_cw;
		logic brake_current_ok;
		logic zero_speed_detect;
	} plant_in_s;

	typedef struct packed {
		logic fire_inhibit;
		logic bypass_on;
		logic brake_fire;
		logic contactor_on;
		logic ready;
		logic zero_speed;
	} drive_s;

	// Type 4 outranks type 2, type 2 outranks type 1, warnings rank lowest.
	function automatic severity_e sev_of(input fault_code_e c);
		unique case (c)
			FC_NONE: sev_of = SEV_NONE;
			FC_W_BRAKE_CUR, FC_W_DEV_TEMP: sev_of = SEV_WARN;
			FC_MAIN_CONT, FC_RELAY, FC_ZS_LVL2: sev_of = SEV_T2;
			FC_CPU: sev_of = SEV_T4;
			default: sev_of = SEV_T1;
		endcase
	endfunction

endpackage

/* rtl/starter_supervisor.sv */
// Function
// R1 - Enable drop cancels condition, motor coasts
// R2 - Supply loss: inhibit firing, all relays off
// R3 - Orderly switch-off at every cycle end; enable drop, supply loss or a fault go straight to standby
// R4 - Show fault, yes/no acknowledge, return menu
// R5 - Braking current missed raises type 3 warning
// R6 - Small heat sink margin raises warning
// R7 - Heat sink over limit: type 1 fault
// R8 - Line voltage after contactor off: type 2
// R9 - Processor errors give type 4 fault
// R10 - Motor temperature sensor trip: type 1
// R11 - Overload at ramp-up end: type 1
// R12 - Phase faults inhibit briefly, repeated: type 1
// R13 - Power unit internal fault: type 1
// R14 - Current not dropping after ramp: type 1
// R15 - Relay sensed versus commanded mismatch: type 2
// R16 - Wrong rotary field after delay: type 1
// R17 - Ramp end not reached in time: type 1
// R18 - No zero speed within braking time: type 1
// R19 - Third zero speed fault becomes type 2
// R20 - Types 1,2,4 shut down; 1,2 lock restart
// R21 - Type 1/3 acknowledge sources; lock clears on enable drop
// R22 - Type 2 acknowledged by panel/input only, then lock clears
// R23 - Type 4 refuses every acknowledgement
// R24 - Most severe reaction wins, one code shown
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module starter_supervisor
	import starter_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// Plant commands and monitors
	input wire logic ctrl_supply_ok,
	input wire logic drive_enable_in,
	input wire logic ramp_up_cmd,
	input wire logic ack_config_input,
	input wire plant_in_s plant,
	// Operator panel
	input wire logic panel_ack_yes,
	output fault_code_e fault_code_out,
	output logic ack_prompt_out,
	output logic menu_return_out,
	// Power stage
	output logic fire_inhibit_out,
	output logic bypass_out,
	output logic brake_fire_out,
	output logic contactor_on_out,
	output logic ready_out,
	output logic zero_speed_out,
	output logic restart_lock_out
);

	// ****************************************
	// Registers and state
	// ****************************************
	logic [3:0] ctrl_r;
	logic [15:0] start_lim_r, rampend_mon_r, brake_max_r, mc_mon_r, cont_dly_r, phase_lim_r;
	logic [3:0] phase_rep_r;
	logic [31:0] rd_data_r;
	logic [17:0] presc_r;
	logic [15:0] tmr_r, mon_r, cdly_r, rly_r, ph_tmr_r;
	logic [3:0] ph_cnt_r;
	logic [1:0] zs_cnt_r;
	logic en_d_r, ack_in_d_r, lock_r, zs_flag_r, menu_r, prompt_r;
	op_state_e state_r, state_nxt;
	fault_code_e code_r, code_nxt, pick;
	drive_s drv_r, drv_nxt;

	// ****************************************
	// Decode
	// ****************************************
	wire logic tick = (presc_r == 18'(TICK_CYCLES - 1));
	wire logic en_fell = en_d_r && !drive_enable_in;
	wire logic ack_in_rose = ctrl_r[CTRL_ACK_EN] && ack_config_input && !ack_in_d_r;
	wire logic zs_en = ctrl_r[CTRL_ZS_EN];
	wire logic running = (state_r != ST_STANDBY) && (state_r != ST_SWITCH_OFF);
	wire logic cont_delay_done = (cdly_r >= cont_dly_r);
	wire logic brake_timeout = (state_r == ST_BRAKING) && (tmr_r >= brake_max_r);
	wire logic zs_event = brake_timeout && zs_en && !plant.zero_speed_detect;
	wire logic zs_third = (zs_cnt_r == ZS_REPEAT - 2'h1);
	wire logic mc_check = (state_r == ST_SWITCH_OFF) && (tmr_r >= mc_mon_r);
	wire logic ph_over = plant.phase_bad && tick && (ph_tmr_r == phase_lim_r);
	wire logic [15:0] hit;

	assign hit[0] = 1'b0;
	assign hit[FC_W_BRAKE_CUR] = (state_r == ST_BRAKING) && !plant.brake_current_ok; // R5
	assign hit[FC_W_DEV_TEMP] = plant.heatsink_margin_low; // R6
	assign hit[FC_DEV_TEMP] = plant.heatsink_over; // R7
	assign hit[FC_MAIN_CONT] = mc_check && plant.line_voltage_present; // R8
	assign hit[FC_CPU] = plant.cpu_error; // R9
	assign hit[FC_MOTOR_TEMP] = plant.motor_temp_trip; // R10
	assign hit[FC_OVERLOAD] = (state_r == ST_RAMP_END) && plant.overcurrent; // R11
	assign hit[FC_PHASE] = drv_r.contactor_on && (ph_cnt_r >= phase_rep_r); // R12
	assign hit[FC_POWER_UNIT] = plant.power_unit_fault; // R13
	assign hit[FC_RAMP_END] = (state_r == ST_SOFT_START) && (mon_r >= rampend_mon_r) // R14
		&& !plant.current_below_limit;
	assign hit[FC_RELAY] = (rly_r >= RELAY_SETTLE_TICKS); // R15
	assign hit[FC_ROTARY] = drv_r.contactor_on && cont_delay_done // R16
		&& ctrl_r[CTRL_ROT_EN] && !plant.rotation_cw;
	assign hit[FC_START_CUR] = (state_r == ST_SOFT_START) && !plant.ramp_done // R17
		&& (tmr_r >= start_lim_r);
	assign hit[FC_ZS_LVL1] = zs_event && !zs_third; // R18
	assign hit[FC_ZS_LVL2] = zs_event && zs_third; // R19

	// Lowest code wins a tie of equal severity, so one code is shown at a time.
	always_comb begin
		pick = FC_NONE;
		for (int i = 1; i < 16; i++) begin
			if (hit[i] && (sev_of(fault_code_e'(4'(i))) > sev_of(pick))) begin // R24
				pick = fault_code_e'(4'(i));
			end
		end
	end

	// ****************************************
	// Acknowledge and restart lock
	// ****************************************
	wire severity_e sev_r = sev_of(code_r);
	wire logic ack_src_any = panel_ack_yes || ack_in_rose;
	wire logic ack_src = (sev_r == SEV_T2) ? ack_src_any // R22
		: (sev_r == SEV_T4) ? 1'b0 // R23
		: (ack_src_any || en_fell); // R21
	wire logic ack_ok = (code_r != FC_NONE) && ack_src && !hit[code_r];
	wire fault_code_e code_cleared = ack_ok ? FC_NONE : code_r;
	wire logic replace = sev_of(pick) > sev_of(code_cleared);
	wire severity_e sev_nxt = sev_of(code_nxt);
	wire logic halt = (sev_nxt >= SEV_T1) || !ctrl_supply_ok; // R2 R20
	wire logic lock_set = replace && ((sev_of(pick) == SEV_T1) || (sev_of(pick) == SEV_T2));
	wire logic lock_hold_t2 = (sev_of(code_cleared) == SEV_T2);
	wire logic lock_nxt = lock_set || (lock_r && !(en_fell && !lock_hold_t2)); // R21 R22

	// A new event in the acknowledge cycle replaces the cleared code rather than being lost.
	assign code_nxt = replace ? pick : code_cleared; // R24

	// ****************************************
	// Operating condition
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_STANDBY: begin
				if (drive_enable_in && ramp_up_cmd && !lock_r) begin
					state_nxt = ST_SOFT_START;
				end
			end
			ST_SOFT_START, ST_RAMP_END: begin
				if (!ramp_up_cmd) begin
					state_nxt = ctrl_r[CTRL_BRAKE_MODE] ? ST_BRAKING : ST_SOFT_STOP;
				end else if (state_r == ST_SOFT_START && plant.ramp_done
					&& plant.current_below_limit) begin
					state_nxt = ST_RAMP_END;
				end
			end
			ST_SOFT_STOP: begin
				if (plant.ramp_down_done) begin
					state_nxt = ST_SWITCH_OFF; // R3
				end
			end
			ST_BRAKING: begin
				if ((zs_en && plant.zero_speed_detect) || brake_timeout) begin
					state_nxt = ST_SWITCH_OFF; // R3
				end
			end
			ST_SWITCH_OFF: begin
				if (mc_check) begin
					state_nxt = ST_STANDBY;
				end
			end
			default: state_nxt = ST_STANDBY;
		endcase
		if (halt || (running && !drive_enable_in)) begin
			state_nxt = ST_STANDBY; // R1 R2 R20
		end
	end

	wire logic zs_flag_nxt = drive_enable_in && !halt && ((state_r == ST_BRAKING && zs_en
		&& plant.zero_speed_detect) || (zs_flag_r && state_nxt != ST_SOFT_START));
	wire logic firing_cond = (state_nxt == ST_SOFT_START) || (state_nxt == ST_SOFT_STOP);

	always_comb begin
		drv_nxt.fire_inhibit = halt || !firing_cond || plant.phase_bad; // R12 R20
		drv_nxt.bypass_on = !halt && (state_nxt == ST_RAMP_END);
		drv_nxt.brake_fire = !halt && (state_nxt == ST_BRAKING);
		drv_nxt.contactor_on = !halt && (state_nxt != ST_STANDBY)
			&& (state_nxt != ST_SWITCH_OFF);
		drv_nxt.ready = !halt && (state_nxt == ST_STANDBY) && (code_nxt == FC_NONE) && !lock_nxt;
		drv_nxt.zero_speed = zs_flag_nxt;
	end

	// ****************************************
	// Sequential logic
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc_r <= '0;
			en_d_r <= 1'b0;
			ack_in_d_r <= 1'b0;
			state_r <= ST_STANDBY;
			code_r <= FC_NONE;
			lock_r <= 1'b0;
			zs_flag_r <= 1'b0;
			menu_r <= 1'b0;
			prompt_r <= 1'b0;
			drv_r <= '{fire_inhibit: 1'b1, default: 1'b0};
		end else begin
			presc_r <= tick ? '0 : presc_r + 18'h00001;
			en_d_r <= drive_enable_in;
			ack_in_d_r <= ack_config_input;
			state_r <= state_nxt;
			code_r <= code_nxt;
			lock_r <= lock_nxt;
			zs_flag_r <= zs_flag_nxt;
			menu_r <= ack_ok && panel_ack_yes; // R4
			prompt_r <= (code_nxt != FC_NONE); // R4
			drv_r <= drv_nxt;
		end
	end

	// Timers run on the millisecond tick; resolution is one tick.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tmr_r <= '0;
			mon_r <= '0;
			cdly_r <= '0;
			rly_r <= '0;
			ph_tmr_r <= '0;
		end else begin
			tmr_r <= (state_nxt != state_r) ? '0 : (tick && tmr_r != 16'hFFFF) ? tmr_r + 16'h0001 : tmr_r;
			mon_r <= (state_r != ST_SOFT_START || !plant.ramp_done) ? '0
				: (tick && mon_r != 16'hFFFF) ? mon_r + 16'h0001 : mon_r; // R14
			cdly_r <= !drv_r.contactor_on ? '0
				: (tick && !cont_delay_done) ? cdly_r + 16'h0001 : cdly_r; // R16
			rly_r <= (plant.contactor_sensed == drv_r.contactor_on) ? '0
				: (tick && !hit[FC_RELAY]) ? rly_r + 16'h0001 : rly_r; // R15
			ph_tmr_r <= !(plant.phase_bad && drv_r.contactor_on) ? '0
				: (tick && ph_tmr_r != 16'hFFFF) ? ph_tmr_r + 16'h0001 : ph_tmr_r;
		end
	end

	// Phase overruns count per operating cycle; zero speed faults count across cycles.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ph_cnt_r <= '0;
			zs_cnt_r <= '0;
		end else begin
			if (state_r == ST_STANDBY) begin
				ph_cnt_r <= '0;
			end else if (ph_over && drv_r.contactor_on && ph_cnt_r != 4'hF) begin
				ph_cnt_r <= ph_cnt_r + 4'h1; // R12
			end
			if (zs_event) begin
				zs_cnt_r <= zs_third ? 2'h0 : zs_cnt_r + 2'h1; // R19
			end else if (state_r == ST_BRAKING && zs_en && plant.zero_speed_detect) begin
				zs_cnt_r <= '0;
			end
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	wire logic [31:0] status_word = {7'h00, drv_r, ph_cnt_r, zs_cnt_r, lock_r, sev_r, code_r,
		2'h0, state_r};
	wire logic [31:0] rd_mux =
		(addr == ADDR_CTRL) ? {28'h0000000, ctrl_r} :
		(addr == ADDR_START_LIM) ? {16'h0000, start_lim_r} :
		(addr == ADDR_RAMPEND_MON) ? {16'h0000, rampend_mon_r} :
		(addr == ADDR_BRAKE_MAX) ? {16'h0000, brake_max_r} :
		(addr == ADDR_MC_MON) ? {16'h0000, mc_mon_r} :
		(addr == ADDR_CONT_DLY) ? {16'h0000, cont_dly_r} :
		(addr == ADDR_PHASE) ? {12'h000, phase_rep_r, phase_lim_r} :
		(addr == ADDR_STATUS) ? status_word : 32'h00000000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= CTRL_RST;
			start_lim_r <= START_LIM_RST;
			rampend_mon_r <= RAMPEND_MON_RST;
			brake_max_r <= BRAKE_MAX_RST;
			mc_mon_r <= MC_MON_RST;
			cont_dly_r <= CONT_DLY_RST;
			phase_lim_r <= PHASE_LIM_RST;
			phase_rep_r <= PHASE_REP_RST;
			rd_data_r <= '0;
		end else begin
			rd_data_r <= rd_en ? rd_mux : 32'h00000000;
			if (wr_en && addr == ADDR_CTRL) ctrl_r <= wr_data[3:0];
			if (wr_en && addr == ADDR_START_LIM) start_lim_r <= wr_data[15:0];
			if (wr_en && addr == ADDR_RAMPEND_MON) rampend_mon_r <= wr_data[15:0];
			if (wr_en && addr == ADDR_BRAKE_MAX) brake_max_r <= wr_data[15:0];
			if (wr_en && addr == ADDR_MC_MON) mc_mon_r <= wr_data[15:0];
			if (wr_en && addr == ADDR_CONT_DLY) cont_dly_r <= wr_data[15:0];
			if (wr_en && addr == ADDR_PHASE) begin
				phase_lim_r <= wr_data[15:0];
				phase_rep_r <= wr_data[PHASE_REP_LSB +: 4];
			end
		end
	end

	assign rd_data = rd_data_r;
	assign fault_code_out = code_r;
	assign ack_prompt_out = prompt_r; // R4
	assign menu_return_out = menu_r;
	assign fire_inhibit_out = drv_r.fire_inhibit;
	assign bypass_out = drv_r.bypass_on;
	assign brake_fire_out = drv_r.brake_fire;
	assign contactor_on_out = drv_r.contactor_on;
	assign ready_out = drv_r.ready;
	assign zero_speed_out = drv_r.zero_speed;
	assign restart_lock_out = lock_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_cancel;
		running && !drive_enable_in |=> state_r == ST_STANDBY && !bypass_out && fire_inhibit_out;
	endproperty
	a_cancel: assert property (p_cancel) else $error("enable drop did not cancel"); // R1

	property p_supply;
		!ctrl_supply_ok |=> fire_inhibit_out && !bypass_out && !brake_fire_out
			&& !contactor_on_out && !ready_out;
	endproperty
	a_supply: assert property (p_supply) else $error("supply loss left outputs on"); // R2

	property p_switch_off;
		state_r == ST_SWITCH_OFF |-> !contactor_on_out && fire_inhibit_out;
	endproperty
	a_switch_off: assert property (p_switch_off) else $error("switch-off kept contactor"); // R3

	property p_menu;
		menu_return_out |-> $past(panel_ack_yes) && $past(ack_prompt_out);
	endproperty
	a_menu: assert property (p_menu) else $error("menu return without panel yes"); // R4

	property p_shutdown;
		sev_r >= SEV_T1 |-> fire_inhibit_out && !bypass_out && !ready_out
			&& !contactor_on_out && !zero_speed_out;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("fault left outputs on"); // R20

	property p_t4_sticks;
		sev_r == SEV_T4 |=> sev_r == SEV_T4;
	endproperty
	a_t4_sticks: assert property (p_t4_sticks) else $error("processor fault cleared"); // R23

	property p_t2_lock;
		sev_r == SEV_T2 && en_fell && !panel_ack_yes && !ack_in_rose |=> restart_lock_out;
	endproperty
	a_t2_lock: assert property (p_t2_lock) else $error("lock cleared before acknowledge"); // R22

	property p_main_cont;
		mc_check && plant.line_voltage_present |=> sev_r >= SEV_T2;
	endproperty
	a_main_cont: assert property (p_main_cont) else $error("main contactor fault missed"); // R8

	property p_lock_start;
		restart_lock_out |=> state_r != ST_SOFT_START || $past(state_r) == ST_SOFT_START;
	endproperty
	a_lock_start: assert property (p_lock_start) else $error("start under restart lock"); // R21

	c_bypass: cover property (state_r == ST_SOFT_START ##1 state_r == ST_RAMP_END);
	c_brake_zero: cover property (state_r == ST_BRAKING ##1 zero_speed_out);
	c_zs_lvl2: cover property (code_r == FC_ZS_LVL2);
	c_t2_ack: cover property (sev_r == SEV_T2 ##1 code_r == FC_NONE);

endmodule

`default_nettype wire

/* tb/motor_plant_model.sv */
`timescale 1ns/1ps
`default_nettype none

module motor_plant_model
	import starter_pkg::*;
(
	// Power stage commands
	input wire logic contactor_on,
	// Test controls
	input wire plant_in_s inj,
	input wire logic relay_stuck,
	// Measurements
	output plant_in_s plant
);
	// ****************************************
	// Contactor and supply feedback
	// ****************************************
	// A welded or miswired relay is modelled by inverting the sensed
	// position, so the mismatch shows whichever way the command points.
	always_comb begin
		plant = inj;
		plant.contactor_sensed = contactor_on ^ relay_stuck;
		plant.line_voltage_present = contactor_on | inj.line_voltage_present;
		plant.rotation_cw = 1'b1;
	end
endmodule

`default_nettype wire

/* tb/motor_starter_fault_supervisor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module motor_starter_fault_supervisor_tb_top;
	import starter_pkg::*;
	logic clk, nrst, wr_en, rd_en, sup, en, ramp, ack_in, pyes, stuck;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data, rv;
	fault_code_e code;
	logic prompt, menu_ret, inh, byp, brk, con, rdy, zs, lock;
	plant_in_s inj, plant;
	int err_total, tests_run;

	starter_supervisor #(.TICK_CYCLES(4)) DUT (
		.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .ctrl_supply_ok(sup), .drive_enable_in(en),
		.ramp_up_cmd(ramp), .ack_config_input(ack_in), .plant(plant),
		.panel_ack_yes(pyes), .fault_code_out(code), .ack_prompt_out(prompt),
		.menu_return_out(menu_ret), .fire_inhibit_out(inh), .bypass_out(byp),
		.brake_fire_out(brk), .contactor_on_out(con), .ready_out(rdy),
		.zero_speed_out(zs), .restart_lock_out(lock)
	);

	motor_plant_model model (.contactor_on(con), .inj(inj), .relay_stuck(stuck), .plant(plant));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************
	// Checking and bus helpers
	// ****************************************
	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask

	// The wait is bounded; running out of it ends the run as a failure.
	task automatic wait_code(input logic [3:0] exp, input int max);
		for (int i = 0; i < max && code !== exp; i++) begin
			@(posedge clk);
			#1;
		end
		chk_word({28'h0, code}, {28'h0, exp}, "code");
		if (code !== exp)
			report_and_stop();
	endtask

	task automatic panel_yes();
		@(posedge clk);
		pyes <= 1'b1;
		@(posedge clk);
		pyes <= 1'b0;
	endtask

	// Standby after a plain cancel reports ready; a fault or supply loss does not.
	task automatic chk_off(input logic exp_rdy);
		chk_bit(inh, 1'b1, "inh");
		chk_bit(byp, 1'b0, "byp");
		chk_bit(con, 1'b0, "con");
		chk_bit(rdy, exp_rdy, "rdy");
		chk_bit(zs, 1'b0, "zs");
		chk_bit(brk, 1'b0, "brk");
	endtask

	task automatic do_reset();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		cyc(2);
	endtask

	task automatic start_run();
		@(posedge clk);
		en <= 1'b1;
		ramp <= 1'b1;
		cyc(2);
	endtask

	task automatic stop_all();
		@(posedge clk);
		en <= 1'b0;
		ramp <= 1'b0;
		cyc(2);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		chk_bit(rdy, 1'b1, "rdy");
		chk_bit(inh, 1'b1, "inh");
		reg_rd(ADDR_CTRL, rv);
		chk_word(rv, 32'h0000_0008, "ctrl");
		reg_rd(ADDR_START_LIM, rv);
		chk_word(rv, 32'h0000_2710, "lim");
		reg_wr(ADDR_STATUS, 32'hFFFF_FFFF);
		reg_rd(ADDR_STATUS, rv);
		chk_word(rv, 32'h0110_0000, "stat");
		reg_rd(8'h22, rv);
		chk_word(rv, 32'h0, "unmap");
		$display("END regs");
	endtask

	task automatic t_cancel();
		start_run();
		chk_bit(con, 1'b1, "con");
		chk_bit(inh, 1'b0, "inh");
		@(posedge clk);
		en <= 1'b0;
		cyc(2);
		chk_off(1'b1);
		reg_rd(ADDR_STATUS, rv);
		chk_word({29'h0, rv[2:0]}, 32'h0, "state");
		stop_all();
		$display("END cancel");
	endtask

	task automatic t_supply();
		start_run();
		@(posedge clk);
		sup <= 1'b0;
		cyc(2);
		chk_off(1'b0);
		@(posedge clk);
		sup <= 1'b1;
		stop_all();
		$display("END supply");
	endtask

	task automatic t_type1();
		int n;
		start_run();
		@(posedge clk);
		inj.motor_temp_trip <= 1'b1;
		wait_code(FC_MOTOR_TEMP, 4);
		chk_off(1'b0);
		chk_bit(lock, 1'b1, "lock");
		chk_bit(prompt, 1'b1, "prompt");
		@(posedge clk);
		inj.motor_temp_trip <= 1'b0;
		panel_yes();
		n = 0;
		repeat (4) begin
			#1;
			if (menu_ret === 1'b1)
				n++;
			@(posedge clk);
		end
		chk_word(n, 1, "menu");
		chk_word({28'h0, code}, 32'h0, "code");
		chk_bit(lock, 1'b1, "lock");
		stop_all();
		chk_bit(lock, 1'b0, "lock");
		chk_bit(rdy, 1'b1, "rdy");
		$display("END type1");
	endtask

	task automatic t_warn();
		reg_wr(ADDR_CTRL, 32'h0000_0009);
		@(posedge clk);
		en <= 1'b1;
		inj.heatsink_margin_low <= 1'b1;
		wait_code(FC_W_DEV_TEMP, 4);
		chk_bit(lock, 1'b0, "lock");
		@(posedge clk);
		inj.heatsink_over <= 1'b1;
		wait_code(FC_DEV_TEMP, 4);
		chk_bit(lock, 1'b1, "lock");
		@(posedge clk);
		inj.heatsink_over <= 1'b0;
		inj.heatsink_margin_low <= 1'b0;
		stop_all();
		wait_code(FC_NONE, 4);
		@(posedge clk);
		inj.heatsink_margin_low <= 1'b1;
		wait_code(FC_W_DEV_TEMP, 4);
		@(posedge clk);
		inj.heatsink_margin_low <= 1'b0;
		ack_in <= 1'b1;
		wait_code(FC_NONE, 4);
		@(posedge clk);
		ack_in <= 1'b0;
		$display("END warn");
	endtask

	task automatic t_relay();
		@(posedge clk);
		en <= 1'b1;
		stuck <= 1'b1;
		wait_code(FC_RELAY, 400);
		chk_bit(lock, 1'b1, "lock");
		@(posedge clk);
		stuck <= 1'b0;
		stop_all();
		chk_word({28'h0, code}, {28'h0, FC_RELAY}, "code");
		chk_bit(lock, 1'b1, "lock");
		panel_yes();
		wait_code(FC_NONE, 4);
		chk_bit(lock, 1'b1, "lock");
		@(posedge clk);
		en <= 1'b1;
		stop_all();
		chk_bit(lock, 1'b0, "lock");
		$display("END relay");
	endtask

	task automatic t_type4();
		@(posedge clk);
		en <= 1'b1;
		inj.cpu_error <= 1'b1;
		wait_code(FC_CPU, 4);
		chk_off(1'b0);
		@(posedge clk);
		inj.cpu_error <= 1'b0;
		panel_yes();
		@(posedge clk);
		ack_in <= 1'b1;
		@(posedge clk);
		ack_in <= 1'b0;
		stop_all();
		chk_word({28'h0, code}, {28'h0, FC_CPU}, "code");
		do_reset();
		chk_word({28'h0, code}, 32'h0, "code");
		$display("END type4");
	endtask

	// Short braking and contactor times keep each braking run to a few ticks.
	task automatic t_brake();
		int k;
		reg_wr(ADDR_CTRL, 32'h0000_000B);
		reg_wr(ADDR_BRAKE_MAX, 32'h0000_0004);
		reg_wr(ADDR_MC_MON, 32'h0000_0002);
		@(posedge clk);
		inj.ramp_done <= 1'b1;
		inj.current_below_limit <= 1'b1;
		inj.zero_speed_detect <= 1'b1;
		start_run();
		chk_bit(byp, 1'b1, "byp");
		@(posedge clk);
		ramp <= 1'b0;
		cyc(1);
		chk_bit(brk, 1'b1, "brk");
		cyc(1);
		chk_word({28'h0, code}, {28'h0, FC_W_BRAKE_CUR}, "code");
		chk_bit(zs, 1'b1, "zs");
		chk_bit(con, 1'b0, "con");
		stop_all();
		cyc(10);
		@(posedge clk);
		inj.zero_speed_detect <= 1'b0;
		inj.brake_current_ok <= 1'b1;
		for (k = 0; k < 3; k++) begin
			start_run();
			@(posedge clk);
			ramp <= 1'b0;
			wait_code((k == 2) ? FC_ZS_LVL2 : FC_ZS_LVL1, 40);
			chk_off(1'b0);
			if (k == 2)
				panel_yes();
			stop_all();
		end
		chk_bit(lock, 1'b0, "lock");
		$display("END brake");
	endtask

	// ****************************************
	// Run control
	// ****************************************
	task automatic report_and_stop();
		$display("COUNTS checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		{nrst, wr_en, rd_en, en, ramp, ack_in, pyes, stuck} = 8'h00;
		sup = 1'b1;
		addr = 8'h00;
		wr_data = 32'h0;
		inj = '0;
		err_total = 0;
		tests_run = 0;
		do_reset();
		t_regs();
		t_cancel();
		t_supply();
		t_type1();
		t_warn();
		t_relay();
		t_type4();
		t_brake();
		report_and_stop();
	end
endmodule

`default_nettype wire
